// file: pkg/qpec_pkg.sv
// constants and carrier types for the quad program / erase command block
package qpec_pkg;
   // ****************************************
   // opcodes
   // ****************************************
   localparam logic [7:0] OP_QPROG = 8'h32;
   localparam logic [7:0] OP_QPROG_W = 8'h34;
   localparam logic [7:0] OP_SECT = 8'h20;
   localparam logic [7:0] OP_SECT_W = 8'h21;
   localparam logic [7:0] OP_HALF = 8'h52;
   localparam logic [7:0] OP_HALF_W = 8'h53;
   localparam logic [7:0] OP_BLK = 8'hd8;
   localparam logic [7:0] OP_BLK_W = 8'hdc;
   localparam logic [7:0] OP_WR_EN = 8'h06;
   // ****************************************
   // geometry
   // ****************************************
   localparam int PAGE_BYTES = 256;
   localparam int PAGE_BITS = 8;
   localparam int SECT_BITS = 12;
   localparam int HALF_BITS = 15;
   localparam int BLK_BITS = 16;
   localparam int HALF_SEL_BIT = 15;
   localparam int ADDR_W = 32;
   localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
   localparam logic [5:0] ADDR_BITS_WIDE = 6'h20;
   localparam logic [5:0] OPC_BITS = 6'h08;
   // ****************************************
   // timing, clock in MHz, job times in microseconds
   // ****************************************
   localparam int CLK_MHZ = 25;
   localparam int T_PROG_US = 400;
   localparam int T_SECT_US = 1000;
   localparam int T_HALF_US = 2000;
   localparam int T_BLK_US = 4000;
   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      QPEC_OP_PROG,
      QPEC_OP_SECT,
      QPEC_OP_HALF,
      QPEC_OP_BLK
   } qpec_op_t;
   // request handed to the array side at the start of a self-timed job
   typedef struct packed {
      qpec_op_t op;
      logic [ADDR_W-1:0] base;
      logic [ADDR_W-1:0] last;
   } qpec_job_t;
   // status bits shown to the host
   typedef struct packed {
      logic write_in_progress;
      logic write_enable_latch;
      logic prog_err;
      logic erase_err;
   } qpec_status_t;
endpackage : qpec_pkg

// file: hdl/qpec_sync.sv
// two flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
module qpec_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff;
   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '0;
         q <= '0;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule : qpec_sync

// file: hdl/qpec_core.sv
// quad page program and sector / half block / block erase command sequencer
// Notes on behaviour
// - opcodes 32h and 34h are quad page program; bits only go one to zero.
// - program data arrives four bits per serial clock on io0..io3.
// - quad program is accepted only when quad enable is one.
// - quad program needs the write enable latch set by a prior write enable.
// - 32h takes 3 or 4 address bytes by select bit; 34h always 4.
// - program runs only if chip select rises on a whole byte boundary.
// - page buffer holds 256 bytes, page aligned, address wraps within the page.
// - program error flag set when programming fails or hits protection.
// - write in progress is high while the program job runs.
// - opcodes 20h and 21h erase the addressed 4 KB sector to ones.
// - every erase needs the write enable latch set.
// - erase starts only if chip select rises right after the last address bit.
// - erase pre-programs then erases, starting when chip select rises.
// - write in progress reads one during erase, zero when done.
// - protected sector erase is skipped and sets the erase error flag.
// - 52h / 53h erase a half block chosen by address bit 15.
// - any protection inside the half block skips it and sets erase error.
// - opcodes D8h and DCh erase the addressed 64 KB block.
// - any protection inside the block skips it and sets erase error.
// - 20h, 52h, D8h follow the select bit; 21h, 53h, DCh take 4 bytes.
// - in four bit command mode opcode and address move four bits per clock.
`timescale 1ns/1ns
module qpec_core #(
   parameter int ARRAY_ADDR_W = 23,
   parameter int PROG_CYC = qpec_pkg::T_PROG_US * qpec_pkg::CLK_MHZ,
   parameter int SECT_CYC = qpec_pkg::T_SECT_US * qpec_pkg::CLK_MHZ,
   parameter int HALF_CYC = qpec_pkg::T_HALF_US * qpec_pkg::CLK_MHZ,
   parameter int BLK_CYC = qpec_pkg::T_BLK_US * qpec_pkg::CLK_MHZ
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // serial pins, sampled
   input wire logic cs_n,
   input wire logic sck,
   input wire logic [3:0] io_in,
   // configuration
   input wire logic address_length_select,
   input wire logic quad_enable,
   input wire logic four_bit_command_mode,
   // protection answer from the array side, combinational on job
   input wire logic range_protected,
   input wire logic prog_fail,
   // software clears for error flags
   input wire logic clr_errors,
   // array side
   output qpec_pkg::qpec_job_t job_ff,
   output logic job_start_ff,
   output logic pre_program_ff,
   output logic buf_we_ff,
   output logic [qpec_pkg::PAGE_BITS-1:0] buf_addr_ff,
   output logic [7:0] buf_data_ff,
   // status
   output qpec_pkg::qpec_status_t status_ff
);
   // ****************************************
   // pin synchronisers and edges
   // ****************************************
   logic [5:0] pins_s;
   logic sck_d_ff;
   logic cs_d_ff;
   // select travels inverted so a synchroniser in reset reads as deselected
   qpec_sync #(.W(6)) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d({~cs_n, sck, io_in}),
      .q(pins_s)
   );
   wire cs_s = ~pins_s[5];
   wire sck_s = pins_s[4];
   wire [3:0] io_s = pins_s[3:0];
   wire sck_rise = sck_s & ~sck_d_ff;
   wire cs_rise = cs_s & ~cs_d_ff;
   // delayed copies for edge detection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_d_ff <= 1'b0;
         cs_d_ff <= 1'b1;
      end else begin
         sck_d_ff <= sck_s;
         cs_d_ff <= cs_s;
      end
   end

   // ****************************************
   // frame sequencer
   // ****************************************
   typedef enum logic [1:0] {
      ST_OPC,
      ST_ADDR,
      ST_DATA,
      ST_SKIP
   } qpec_frame_t;
   qpec_frame_t frame_ff;
   logic [5:0] bit_cnt_ff;
   logic [7:0] opc_ff;
   logic [qpec_pkg::ADDR_W-1:0] addr_ff;
   logic [5:0] addr_len_ff;
   logic [7:0] byte_ff;
   logic [2:0] dbit_ff;
   logic data_seen_ff;
   logic busy_ff;
   logic [31:0] timer_ff;

   // lane count: quad for program data and in four bit mode
   wire quad_lane = four_bit_command_mode | (frame_ff == ST_DATA);
   wire [5:0] step = quad_lane ? 6'h04 : 6'h01;
   wire [7:0] opc_nxt = quad_lane ? {opc_ff[3:0], io_s} : {opc_ff[6:0], io_s[0]};
   wire [qpec_pkg::ADDR_W-1:0] addr_nxt = quad_lane ? {addr_ff[27:0], io_s}
      : {addr_ff[30:0], io_s[0]};
   wire [7:0] byte_nxt = {byte_ff[3:0], io_s};
   wire [5:0] cnt_nxt = bit_cnt_ff + step;

   // opcode classification
   wire [7:0] opc_now = opc_nxt;
   wire is_prog = (opc_now == qpec_pkg::OP_QPROG) || (opc_now == qpec_pkg::OP_QPROG_W);
   wire is_sect = (opc_now == qpec_pkg::OP_SECT) || (opc_now == qpec_pkg::OP_SECT_W);
   wire is_half = (opc_now == qpec_pkg::OP_HALF) || (opc_now == qpec_pkg::OP_HALF_W);
   wire is_blk = (opc_now == qpec_pkg::OP_BLK) || (opc_now == qpec_pkg::OP_BLK_W);
   wire is_wide = (opc_now == qpec_pkg::OP_QPROG_W) || (opc_now == qpec_pkg::OP_SECT_W)
      || (opc_now == qpec_pkg::OP_HALF_W) || (opc_now == qpec_pkg::OP_BLK_W);
   // preconditions: latch set, quad set for program, not already busy
   wire prog_ok = status_ff.write_enable_latch & quad_enable;
   wire erase_ok = status_ff.write_enable_latch;
   wire accept = ~busy_ff & ((is_prog & prog_ok) | ((is_sect | is_half | is_blk) & erase_ok));
   wire [5:0] len_sel = (is_wide | address_length_select) ? qpec_pkg::ADDR_BITS_WIDE
      : qpec_pkg::ADDR_BITS_NARROW;

   // shift engine, one step per sampled serial clock rise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_ff <= ST_OPC;
         bit_cnt_ff <= '0;
         opc_ff <= '0;
         addr_ff <= '0;
         addr_len_ff <= qpec_pkg::ADDR_BITS_NARROW;
         byte_ff <= '0;
         dbit_ff <= '0;
         data_seen_ff <= 1'b0;
      end else if (cs_s) begin
         frame_ff <= ST_OPC;
         bit_cnt_ff <= '0;
         dbit_ff <= '0;
         data_seen_ff <= 1'b0;
      end else if (sck_rise) begin
         unique case (frame_ff)
            ST_OPC: begin
               opc_ff <= opc_nxt;
               bit_cnt_ff <= cnt_nxt;
               if (cnt_nxt == qpec_pkg::OPC_BITS) begin
                  // a refused opcode other than write enable can never launch
                  bit_cnt_ff <= (accept || opc_nxt == qpec_pkg::OP_WR_EN) ? '0 : step;
                  addr_ff <= '0;
                  addr_len_ff <= len_sel;
                  frame_ff <= accept ? ST_ADDR : ST_SKIP;
               end
            end
            ST_ADDR: begin
               addr_ff <= addr_nxt;
               bit_cnt_ff <= cnt_nxt;
               if (cnt_nxt == addr_len_ff) begin
                  bit_cnt_ff <= '0;
                  // program goes on to data, erase frames must now end
                  frame_ff <= (opc_ff == qpec_pkg::OP_QPROG || opc_ff == qpec_pkg::OP_QPROG_W)
                     ? ST_DATA : ST_SKIP;
               end
            end
            ST_DATA: begin
               byte_ff <= byte_nxt;
               dbit_ff <= dbit_ff + 3'h4;
               if (dbit_ff == 3'h4) begin
                  data_seen_ff <= 1'b1;
               end
            end
            ST_SKIP: begin
               bit_cnt_ff <= step; // nonzero, no wrap back to zero
            end
         endcase
      end
   end

   // ****************************************
   // page buffer write port
   // ****************************************
   logic [qpec_pkg::PAGE_BITS-1:0] page_ptr_ff;
   // bytes go to buffer offset, wrapping inside the page
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_we_ff <= 1'b0;
         buf_addr_ff <= '0;
         buf_data_ff <= '0;
         page_ptr_ff <= '0;
      end else begin
         buf_we_ff <= 1'b0;
         if (frame_ff == ST_ADDR && sck_rise && cnt_nxt == addr_len_ff) begin
            page_ptr_ff <= addr_nxt[qpec_pkg::PAGE_BITS-1:0];
         end else if (frame_ff == ST_DATA && sck_rise && dbit_ff == 3'h4 && !cs_s) begin
            buf_we_ff <= 1'b1;
            buf_addr_ff <= page_ptr_ff;
            buf_data_ff <= byte_nxt;
            page_ptr_ff <= page_ptr_ff + 8'h01;
         end
      end
   end

   // ****************************************
   // launch decision at chip select rise
   // ****************************************
   wire opc_prog_f = (opc_ff == qpec_pkg::OP_QPROG) || (opc_ff == qpec_pkg::OP_QPROG_W);
   wire opc_sect_f = (opc_ff == qpec_pkg::OP_SECT) || (opc_ff == qpec_pkg::OP_SECT_W);
   wire opc_half_f = (opc_ff == qpec_pkg::OP_HALF) || (opc_ff == qpec_pkg::OP_HALF_W);
   wire opc_blk_f = (opc_ff == qpec_pkg::OP_BLK) || (opc_ff == qpec_pkg::OP_BLK_W);
   // program: on a byte boundary with at least one byte
   wire go_prog = cs_rise & (frame_ff == ST_DATA) & data_seen_ff
      & (dbit_ff == 3'h0) & opc_prog_f;
   // erase: straight after the last address bit, nothing more clocked
   wire go_erase = cs_rise & (frame_ff == ST_SKIP) & (bit_cnt_ff == '0)
      & (opc_sect_f | opc_half_f | opc_blk_f) & status_ff.write_enable_latch;
   wire wr_en_seen = cs_rise & (frame_ff == ST_SKIP) & (bit_cnt_ff == '0)
      & (opc_ff == qpec_pkg::OP_WR_EN) & ~busy_ff;

   // address limited to the array, then aligned to the job size
   logic [qpec_pkg::ADDR_W-1:0] addr_arr;
   logic [qpec_pkg::ADDR_W-1:0] base_nxt;
   logic [qpec_pkg::ADDR_W-1:0] last_nxt;
   qpec_pkg::qpec_op_t op_nxt;
   logic [31:0] dur_nxt;
   always_comb begin
      addr_arr = addr_ff & ((32'h1 << ARRAY_ADDR_W) - 32'h1);
      base_nxt = addr_arr;
      last_nxt = addr_arr;
      op_nxt = qpec_pkg::QPEC_OP_PROG;
      dur_nxt = 32'(PROG_CYC);
      if (opc_prog_f) begin
         base_nxt = addr_arr & ~((32'h1 << qpec_pkg::PAGE_BITS) - 32'h1);
         last_nxt = base_nxt | ((32'h1 << qpec_pkg::PAGE_BITS) - 32'h1);
      end else if (opc_sect_f) begin
         op_nxt = qpec_pkg::QPEC_OP_SECT;
         dur_nxt = 32'(SECT_CYC);
         base_nxt = addr_arr & ~((32'h1 << qpec_pkg::SECT_BITS) - 32'h1);
         last_nxt = base_nxt | ((32'h1 << qpec_pkg::SECT_BITS) - 32'h1);
      end else if (opc_half_f) begin
         op_nxt = qpec_pkg::QPEC_OP_HALF;
         dur_nxt = 32'(HALF_CYC);
         // bit 15 keeps its value and picks sectors 0-7 or 8-15
         base_nxt = addr_arr & ~((32'h1 << qpec_pkg::HALF_BITS) - 32'h1);
         last_nxt = base_nxt | ((32'h1 << qpec_pkg::HALF_BITS) - 32'h1);
      end else if (opc_blk_f) begin
         op_nxt = qpec_pkg::QPEC_OP_BLK;
         dur_nxt = 32'(BLK_CYC);
         base_nxt = addr_arr & ~((32'h1 << qpec_pkg::BLK_BITS) - 32'h1);
         last_nxt = base_nxt | ((32'h1 << qpec_pkg::BLK_BITS) - 32'h1);
      end
   end

   // ****************************************
   // self-timed job and status
   // ****************************************
   logic check_ff;
   logic [31:0] dur_ff;
   // job registration, protection check one cycle later
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         job_ff <= '0;
         check_ff <= 1'b0;
         dur_ff <= '0;
      end else begin
         check_ff <= go_prog | go_erase;
         if (go_prog | go_erase) begin
            job_ff.op <= op_nxt;
            job_ff.base <= base_nxt;
            job_ff.last <= last_nxt;
            dur_ff <= dur_nxt;
         end
      end
   end

   // busy timer; erase runs pre-program half then erase half
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_ff <= 1'b0;
         timer_ff <= '0;
         job_start_ff <= 1'b0;
         pre_program_ff <= 1'b0;
      end else begin
         job_start_ff <= 1'b0;
         if (go_prog | go_erase) begin
            busy_ff <= 1'b1;
         end else if (check_ff) begin
            if (range_protected) begin
               busy_ff <= 1'b0;
            end else begin
               job_start_ff <= 1'b1;
               timer_ff <= dur_ff;
               pre_program_ff <= (job_ff.op != qpec_pkg::QPEC_OP_PROG);
            end
         end else if (busy_ff) begin
            if (timer_ff <= 32'h1) begin
               busy_ff <= 1'b0;
               pre_program_ff <= 1'b0;
            end else begin
               timer_ff <= timer_ff - 32'h1;
               if (timer_ff == (dur_ff >> 1)) begin
                  pre_program_ff <= 1'b0;
               end
            end
         end
      end
   end

   // status flags; a set in the same cycle as a clear wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_ff <= '0;
      end else begin
         status_ff.write_in_progress <= busy_ff | go_prog | go_erase;
         if (wr_en_seen) begin
            status_ff.write_enable_latch <= 1'b1;
         end else if (busy_ff && !check_ff && timer_ff <= 32'h1 && !job_start_ff) begin
            status_ff.write_enable_latch <= 1'b0;
         end else if (check_ff && range_protected) begin
            status_ff.write_enable_latch <= 1'b0;
         end
         if (check_ff && range_protected && job_ff.op == qpec_pkg::QPEC_OP_PROG) begin
            status_ff.prog_err <= 1'b1;
         end else if (busy_ff && prog_fail && job_ff.op == qpec_pkg::QPEC_OP_PROG) begin
            status_ff.prog_err <= 1'b1;
         end else if (clr_errors) begin
            status_ff.prog_err <= 1'b0;
         end
         if (check_ff && range_protected && job_ff.op != qpec_pkg::QPEC_OP_PROG) begin
            status_ff.erase_err <= 1'b1;
         end else if (clr_errors) begin
            status_ff.erase_err <= 1'b0;
         end
      end
   end
endmodule : qpec_core

// file: tb/qpec_core_props.sv
// property checker for the quad program and erase command block
`timescale 1ns/1ns
module qpec_core_props #(
   parameter int BLK_CYC = 100000
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pins and controls
   input wire logic cs_n,
   input wire logic range_protected,
   input wire logic clr_errors,
   // outputs under watch
   input wire qpec_pkg::qpec_job_t job_ff,
   input wire logic job_start_ff,
   input wire logic pre_program_ff,
   input wire logic buf_we_ff,
   input wire qpec_pkg::qpec_status_t status_ff
);
   int busy_cnt_ff;
   // length of the current busy stretch
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) busy_cnt_ff <= 0;
      else busy_cnt_ff <= status_ff.write_in_progress ? busy_cnt_ff + 1 : 0;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_start_pulse:
      assert property (job_start_ff |=> !job_start_ff) else $error("start pulse too long");
   a_start_busy:
      assert property (job_start_ff |-> status_ff.write_in_progress)
      else $error("job started while idle");
   a_byte_pulse:
      assert property (buf_we_ff |=> !buf_we_ff) else $error("byte strobe too long");
   a_busy_latch:
      assert property ($rose(status_ff.write_in_progress) |-> status_ff.write_enable_latch)
      else $error("busy without write enable latch");
   a_busy_cs:
      assert property ($rose(status_ff.write_in_progress) |-> cs_n)
      else $error("busy while chip selected");
   a_free_start:
      assert property ($rose(status_ff.write_in_progress) && !range_protected |=> job_start_ff)
      else $error("free range did not start");
   a_prot_skip:
      assert property ($rose(status_ff.write_in_progress) && range_protected &&
         job_ff.op != qpec_pkg::QPEC_OP_PROG |=> status_ff.erase_err && !job_start_ff)
      else $error("protected erase not refused");
   a_busy_bound:
      assert property (busy_cnt_ff <= BLK_CYC + 4) else $error("busy too long");
   a_pre_prog:
      assert property (pre_program_ff |-> status_ff.write_in_progress &&
         job_ff.op != qpec_pkg::QPEC_OP_PROG) else $error("pre program out of erase");
   a_err_hold:
      assert property (status_ff.erase_err && !clr_errors |=> status_ff.erase_err)
      else $error("erase error lost");
   a_half_span:
      assert property (job_start_ff && job_ff.op == qpec_pkg::QPEC_OP_HALF |->
         job_ff.last - job_ff.base == 32'h0000_7fff) else $error("half block span wrong");
   c_err: cover property ($rose(status_ff.erase_err));
   c_blk: cover property (job_start_ff && job_ff.op == qpec_pkg::QPEC_OP_BLK);
   c_byte: cover property (buf_we_ff);
endmodule : qpec_core_props
bind qpec_core qpec_core_props #(.BLK_CYC(BLK_CYC)) qpec_core_props_inst (.clk(clk),
   .rst_n(rst_n), .cs_n(cs_n), .range_protected(range_protected), .clr_errors(clr_errors),
   .job_ff(job_ff), .job_start_ff(job_start_ff), .pre_program_ff(pre_program_ff),
   .buf_we_ff(buf_we_ff), .status_ff(status_ff));

// file: tb/qpec_host.sv
// host side model framing commands on the serial pins
`timescale 1ns/1ns
module qpec_host (
   // clock
   input wire logic clk,
   // pins toward the device
   output logic cs_n,
   output logic sck,
   output logic [3:0] io_in
);
   // idle pins at time zero
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      io_in = 4'h5;
   end
   // one slow serial clock, four clocks low then four high
   task automatic tick(input logic [3:0] v);
      io_in = v;
      repeat (4) @(negedge clk);
      sck = 1'b1;
      repeat (4) @(negedge clk);
      sck = 1'b0;
   endtask : tick
   // n bits msb first, one or four per serial clock
   task automatic shift(input logic [31:0] v, input int n, input bit quad);
      for (int i = n - 1; i >= 0; i -= (quad ? 4 : 1)) begin
         tick(quad ? v[i -: 4] : {3'h0, v[i]});
      end
   endtask : shift
   task automatic open_frame();
      @(negedge clk);
      cs_n = 1'b0;
   endtask : open_frame
   // released lines flip so no stale level reads as data
   task automatic close_frame();
      cs_n = 1'b1;
      io_in = ~io_in;
      repeat (8) @(negedge clk);
   endtask : close_frame
endmodule : qpec_host

// file: tb/tb_qpec_core.sv
// self-checking bench for the quad program and erase command block
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_qpec_core;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic als = 1'b0;
   logic qe = 1'b0;
   logic quad_cmd = 1'b0;
   logic prot = 1'b0;
   logic pfail = 1'b0;
   logic clr = 1'b0;
   logic cs_n, sck, we, go, pre;
   logic [3:0] io;
   logic [7:0] wa, wd;
   qpec_pkg::qpec_job_t job;
   qpec_pkg::qpec_status_t st;
   int miscompares = 0;
   int checks_done = 0;
   int starts = 0;
   int cyc = 0;
   int n0;
   logic [15:0] wr_q[$];
   localparam logic [7:0] EOPS [6] = '{qpec_pkg::OP_SECT, qpec_pkg::OP_SECT_W,
      qpec_pkg::OP_HALF, qpec_pkg::OP_HALF_W, qpec_pkg::OP_BLK, qpec_pkg::OP_BLK_W};
   localparam qpec_pkg::qpec_op_t KIND [3] = '{qpec_pkg::QPEC_OP_SECT, qpec_pkg::QPEC_OP_HALF,
      qpec_pkg::QPEC_OP_BLK};
   localparam logic [31:0] SPAN [3] = '{32'h0000_0fff, 32'h0000_7fff, 32'h0000_ffff};
   always #20 clk = ~clk;
   qpec_host qpec_host_inst (.clk(clk), .cs_n(cs_n), .sck(sck), .io_in(io));
   qpec_core #(.PROG_CYC(40), .SECT_CYC(30), .HALF_CYC(40), .BLK_CYC(50)) qpec_core_inst (
      .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .io_in(io),
      .address_length_select(als), .quad_enable(qe), .four_bit_command_mode(quad_cmd),
      .range_protected(prot), .prog_fail(pfail), .clr_errors(clr), .job_ff(job),
      .job_start_ff(go), .pre_program_ff(pre), .buf_we_ff(we), .buf_addr_ff(wa),
      .buf_data_ff(wd), .status_ff(st));
   // count job starts, collect buffer writes, cut a hang short
   always @(negedge clk) begin
      cyc++;
      if (go) starts++;
      if (we) wr_q.push_back({wa, wd});
      if (cyc == 20000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   task automatic cmd(input logic [7:0] op, input logic [31:0] a, input int n, input bit q);
      qpec_host_inst.open_frame();
      qpec_host_inst.shift({24'h0, op}, 8, q);
      qpec_host_inst.shift(a, n, q);
   endtask : cmd
   task automatic set_latch(input bit q);
      cmd(qpec_pkg::OP_WR_EN, 32'h0, 0, q);
      qpec_host_inst.close_frame();
      `CHK(st.write_enable_latch, 1'b1)
   endtask : set_latch
   task automatic wait_idle();
      int k = 0;
      while (st.write_in_progress === 1'b1 && k < 60) begin
         @(negedge clk);
         k++;
      end
      `CHK(st.write_in_progress, 1'b0)
   endtask : wait_idle
   // main sequence
   initial begin
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      for (int i = 0; i < 6; i++) begin
         als = (i == 2);
         quad_cmd = i[0];
         set_latch(quad_cmd);
         n0 = starts;
         cmd(EOPS[i], 32'h8f92_9abc, (i[0] || als) ? 32 : 24, quad_cmd);
         qpec_host_inst.close_frame();
         `CHK(st.write_in_progress, 1'b1)
         `CHK(pre, 1'b1)
         `CHK(job.op, KIND[i / 2])
         `CHK(job.base, 32'h0012_9abc & ~SPAN[i / 2])
         `CHK(job.last, 32'h0012_9abc | SPAN[i / 2])
         `CHK(starts, n0 + 1)
         wait_idle();
         `CHK(st.write_enable_latch, 1'b0)
      end
      quad_cmd = 1'b0;
      $display("test erase_table done");
      for (int i = 0; i < 2; i++) begin
         if (i == 1) set_latch(1'b0);
         n0 = starts;
         cmd(qpec_pkg::OP_SECT, 32'h0001_0000, 24 + i, 1'b0);
         qpec_host_inst.close_frame();
         `CHK(st.write_in_progress, 1'b0)
         `CHK(starts, n0)
      end
      $display("test erase_refused done");
      prot = 1'b1;
      for (int i = 0; i < 3; i++) begin
         set_latch(1'b0);
         n0 = starts;
         cmd(EOPS[2 * i], 32'h0003_0000, 24, 1'b0);
         qpec_host_inst.close_frame();
         `CHK(st.erase_err, 1'b1)
         `CHK(st.write_in_progress, 1'b0)
         `CHK(starts, n0)
         clr = 1'b1;
         @(negedge clk);
         clr = 1'b0;
         `CHK(st.erase_err, 1'b0)
      end
      prot = 1'b0;
      $display("test erase_protected done");
      qe = 1'b1;
      // third pass: short opcode with the long address selected
      for (int j = 0; j < 3; j++) begin
         als = (j == 2);
         set_latch(1'b0);
         wr_q.delete();
         cmd((j == 1) ? qpec_pkg::OP_QPROG_W : qpec_pkg::OP_QPROG, 32'h8012_01fe,
            j ? 32 : 24, 1'b0);
         qpec_host_inst.shift(32'h00a5_3ce1, 24, 1'b1);
         qpec_host_inst.close_frame();
         `CHK(st.write_in_progress, 1'b1)
         `CHK(job.op, qpec_pkg::QPEC_OP_PROG)
         `CHK(wr_q.size(), 3)
         `CHK({wr_q[0], wr_q[1], wr_q[2]}, 48'hfea5_ff3c_00e1)
         pfail = j[0];
         @(negedge clk);
         pfail = 1'b0;
         `CHK(st.prog_err, j[0])
         wait_idle();
         clr = 1'b1;
         @(negedge clk);
         clr = 1'b0;
      end
      als = 1'b0;
      $display("test quad_program done");
      for (int j = 0; j < 2; j++) begin
         qe = j[0];
         set_latch(1'b0);
         cmd(qpec_pkg::OP_QPROG_W, 32'h0012_0300, 32, 1'b0);
         qpec_host_inst.shift(32'h0000_0a5c, 8 + 4 * j, 1'b1);
         qpec_host_inst.close_frame();
         `CHK(st.write_in_progress, 1'b0)
      end
      $display("test program_refused done");
      give_verdict();
   end
endmodule : tb_qpec_core
